// >>> hw/icu_regs.svh
// Register offsets, field positions, reset values and counts of the capture channel
`ifndef ICU_REGS_SVH
`define ICU_REGS_SVH
// ****************************************************************
// Bus geometry and register byte addresses
// ****************************************************************
`define ICU_ADDR_W 12
`define ICU_CON1_ADDR 12'h000
`define ICU_CON2_ADDR 12'h004
`define ICU_BUF_ADDR 12'h008
`define ICU_TMR_ADDR 12'h00C
`define ICU_RESP_OKAY 2'h0
`define ICU_RESP_SLVERR 2'h2
// ****************************************************************
// Field positions
// ****************************************************************
`define ICU_SIDL_BIT 13
`define ICU_TSEL_LSB 10
`define ICU_CI_LSB 5
`define ICU_OV_BIT 4
`define ICU_BNE_BIT 3
`define ICU_MODE_LSB 0
`define ICU_CASC_BIT 8
`define ICU_TRIGOP_BIT 7
`define ICU_TSTAT_BIT 6
`define ICU_SSEL_LSB 0
// ****************************************************************
// Reset values, writable masks and counts
// ****************************************************************
`define ICU_CON1_RST 16'h0000
`define ICU_CON2_RST 16'h000D
`define ICU_CON1_WMASK 16'h3C67
`define ICU_CON2_WMASK 16'h01DF
`define ICU_TMR_WMASK 16'hFFFF
`define ICU_TMR_MAX 16'hFFFF
`define ICU_FIFO_DEPTH 3'h4
`define ICU_PRE4_LAST 4'h3
`define ICU_PRE16_LAST 4'hF
`endif

// >>> hw/icu_pkg.sv
// Types shared by the capture channel and its bench
`include "icu_regs.svh"
package icu_pkg;
  // AXI4-Lite requests from the master
  typedef struct packed {
    logic awvalid;
    logic [`ICU_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ICU_ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;
  // AXI4-Lite answers of the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
  // Capture mode codes
  typedef enum logic [2:0] {
    CM_OFF = 3'h0, CM_ANY_EDGE = 3'h1, CM_FALL = 3'h2, CM_RISE = 3'h3,
    CM_PRE4 = 3'h4, CM_PRE16 = 3'h5, CM_UNUSED = 3'h6, CM_SLEEP_PIN = 3'h7
  } cap_mode_t;
  // Time base codes
  typedef enum logic [2:0] {
    TB_TIMER3 = 3'h0, TB_TIMER2 = 3'h1, TB_TIMER4 = 3'h2, TB_TIMER5 = 3'h3,
    TB_TIMER1 = 3'h4, TB_RSV5 = 3'h5, TB_RSV6 = 3'h6, TB_PERIPH = 3'h7
  } tb_sel_t;
  // Whole state of the channel
  typedef struct packed {
    axi_rsp_t rsp;
    logic aw_got;
    logic w_got;
    logic [`ICU_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] timer;
    logic pin_q;
    logic [3:0] pre_cnt;
    logic [1:0] int_cnt;
    logic [3:0][15:0] fifo;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] count;
    logic ovf;
    logic irq;
    logic cap_evt;
    logic carry;
  } state_t;
endpackage

// >>> hw/input_capture_unit.sv
// Input capture channel with AXI4-Lite registers
//
// How it works
// (RULE_01) Stop bit freezes channel in CPU Idle
// (RULE_02) Three-bit field picks capture timer clock
// (RULE_03) Interrupt after one to four captures
// (RULE_04) Count field ignored in modes 001, 111
// (RULE_05) Read-only sticky overflow flag on buffer overflow
// (RULE_06) Read-only flag high while buffer holds data
// (RULE_07) Modes 011, 010 capture rising, falling
// (RULE_08) Modes 100, 101 capture 4th, 16th rise
// (RULE_09) Mode 001 captures on both edges
// (RULE_10) Mode 111: rising-edge wake interrupt only
// (RULE_11) Modes 000 and 110 disable the channel
// (RULE_12) Cascade only when both pair bits set
// (RULE_13) Trigger bit chooses trigger or sync operation
// (RULE_14) Status one means running; zero holds clear
// (RULE_15) Source sets status; software reads, writes it
// (RULE_16) Five codes leave the timer unsynchronised
// (RULE_17) Source codes map onto on-chip event sources
// (RULE_18) Software uses ADC, comparators only to trigger
// (RULE_19) Channel never selects itself as source
// (RULE_20) Source select resets to timer3 code
// (RULE_21) Channel gets its own trigger generator output
// (RULE_22) Unimplemented control bits read as zero
// (RULE_23) Four-entry buffer holds captured timer values
// (RULE_24) Own 16-bit counter on selected clock
// (RULE_25) Edge pushes timer; full buffer sets overflow
// (RULE_26) Buffer read returns oldest value, removes it
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "icu_regs.svh"
module input_capture_unit #(
  parameter int CHANNEL = 1,      // Channel number 1 to 8
  parameter bit IS_UPPER = 1'b0   // High half of a cascaded pair
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire icu_pkg::axi_req_t I_AXI,
  input wire logic I_CAP_PIN,
  input wire logic I_CPU_IDLE,
  input wire logic I_CPU_SLEEP,
  input wire logic [4:0] I_TIMER_CLOCK,
  input wire logic [7:0] I_OC_EVENT,
  input wire logic [3:0] I_TRIG_GEN_OUT,
  input wire logic [4:0] I_TIMER_EVENT,
  input wire logic [7:0] I_IC_EVENT,
  input wire logic [2:0] I_CMP_EVENT,
  input wire logic I_ADC_EVENT,
  input wire logic I_CHARGE_TIME_EVENT,
  input wire logic I_PARTNER_CASCADE,
  input wire logic I_PARTNER_CARRY,
  input wire logic I_PARTNER_CAPTURE,
  output logic O_IRQ,
  output logic O_CAPTURE_EVT,
  output logic O_CASCADE_EN,
  output logic O_TIMER_CARRY,
  output icu_pkg::axi_rsp_t O_AXI
);
  import icu_pkg::*;

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  // Generator outputs 8..11 repeat every four channels
  localparam logic [1:0] PTG_IDX = 2'((CHANNEL - 1) % 4);
  localparam logic [2:0] SELF_IDX = 3'(CHANNEL - 1);
  // Reset image; readies idle high so the first request is taken at once
  localparam state_t ST_RST = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    con1: `ICU_CON1_RST,
    con2: `ICU_CON2_RST,
    default: '0
  };

  // Time base tick of the selected source
  function automatic logic tick_sel(input tb_sel_t sel, input logic [4:0] tmr);
    logic t;
    t = 1'b0;
    unique case (sel)
      TB_PERIPH: t = 1'b1;
      TB_TIMER1: t = tmr[0];
      TB_TIMER2: t = tmr[1];
      TB_TIMER3: t = tmr[2];
      TB_TIMER4: t = tmr[3];
      TB_TIMER5: t = tmr[4];
      TB_RSV5, TB_RSV6: t = 1'b0;  // Reserved: timer stands still
    endcase
    return t;
  endfunction

  // Byte-lane merge of a 16-bit register, masked to its writable bits
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v & m;
  endfunction

  // ****************************************************************
  // State and decoded controls
  // ****************************************************************
  state_t st;       // Registered state
  state_t next_st;  // Next state
  cap_mode_t mode;  // Capture mode
  logic halted;     // Channel frozen by Idle or Sleep
  logic live;       // Not halted
  logic run;        // Capturing mode and not halted
  logic rise;       // Rising edge of the pin
  logic fall;       // Falling edge of the pin
  logic casc_upper; // Acting as high half of a pair
  logic [31:0] src; // Event sources by select code
  logic fire;       // Selected source fired
  logic tick;       // Capture timer advance
  logic qual;       // Qualifying capture edge
  logic pop;        // Buffer read accepted
  logic wr_now;     // Register write performed this cycle
  logic [15:0] head; // Oldest stored value
  logic [15:0] con1_view; // Readback of control one

  assign mode = cap_mode_t'(st.con1[`ICU_MODE_LSB +: 3]);
  // Sleep stops the peripheral clock, so capturing stops too
  assign halted = (st.con1[`ICU_SIDL_BIT] & I_CPU_IDLE) | I_CPU_SLEEP; // see (RULE_01)
  assign live = !halted;
  // Off, unused and wake modes never capture
  assign run = live && mode != CM_OFF && mode != CM_UNUSED && mode != CM_SLEEP_PIN; // see (RULE_11)
  assign rise = I_CAP_PIN & !st.pin_q;
  assign fall = !I_CAP_PIN & st.pin_q;
  assign casc_upper = IS_UPPER && st.con2[`ICU_CASC_BIT] && I_PARTNER_CASCADE; // see (RULE_12)
  assign head = st.fifo[st.rd_ptr];
  assign wr_now = st.aw_got && st.w_got && !st.rsp.bvalid;

  // Source vector indexed by the select code; unsynchronised codes are zero
  always_comb begin
    src = {3'h0, I_CHARGE_TIME_EVENT, I_ADC_EVENT, I_CMP_EVENT, I_IC_EVENT,
           I_TIMER_EVENT, I_TRIG_GEN_OUT[PTG_IDX], 1'b0, I_OC_EVENT, 1'b0}; // see (RULE_16) (RULE_17) (RULE_21)
    src[16 + SELF_IDX] = 1'b0;  // Own capture event would loop back, see (RULE_19)
  end
  assign fire = src[st.con2[`ICU_SSEL_LSB +: 5]];

  // Low half runs on its time base, high half on the partner carry
  assign tick = casc_upper ? I_PARTNER_CARRY
              : tick_sel(tb_sel_t'(st.con1[`ICU_TSEL_LSB +: 3]), I_TIMER_CLOCK); // see (RULE_02)

  // Control one readback with the live status flags
  always_comb begin
    con1_view = st.con1;
    con1_view[`ICU_OV_BIT] = st.ovf;  // see (RULE_05)
    con1_view[`ICU_BNE_BIT] = st.count != 3'h0;  // see (RULE_06)
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st = st;
    qual = 1'b0;
    pop = 1'b0;
    next_st.irq = 1'b0;
    next_st.cap_evt = 1'b0;
    next_st.carry = 1'b0;
    next_st.pin_q = I_CAP_PIN;

    // Capture timer: held, synchronised or counting
    if (live) begin
      if (st.con2[`ICU_TRIGOP_BIT] && !st.con2[`ICU_TSTAT_BIT]) begin
        next_st.timer = 16'h0000;  // Waiting for trigger, see (RULE_13) (RULE_14)
      end else if (!st.con2[`ICU_TRIGOP_BIT] && fire) begin
        next_st.timer = 16'h0000;  // Sync restart, see (RULE_13)
      end else if (tick) begin
        next_st.timer = st.timer + 16'h0001;  // see (RULE_24)
        next_st.carry = st.timer == `ICU_TMR_MAX;
      end
    end

    // Edge qualification per mode
    if (mode != CM_PRE4 && mode != CM_PRE16) begin
      next_st.pre_cnt = 4'h0;
    end
    unique case (mode)
      CM_OFF, CM_UNUSED: qual = 1'b0;  // see (RULE_11)
      CM_ANY_EDGE: qual = rise | fall;  // see (RULE_09)
      CM_FALL: qual = fall;  // see (RULE_07)
      CM_RISE: qual = rise;  // see (RULE_07)
      CM_PRE4: begin
        if (rise && live) begin
          qual = st.pre_cnt == `ICU_PRE4_LAST;  // see (RULE_08)
          next_st.pre_cnt = qual ? 4'h0 : st.pre_cnt + 4'h1;
        end
      end
      CM_PRE16: begin
        if (rise && live) begin
          qual = st.pre_cnt == `ICU_PRE16_LAST;  // see (RULE_08)
          next_st.pre_cnt = qual ? 4'h0 : st.pre_cnt + 4'h1;
        end
      end
      CM_SLEEP_PIN: begin
        // Wake interrupt only; the other settings play no part
        if ((I_CPU_SLEEP || I_CPU_IDLE) && rise) begin
          next_st.irq = 1'b1;  // see (RULE_10)
        end
      end
    endcase
    qual = qual && run;
    // High half captures with the low half; both lag one cycle together
    if (casc_upper) begin
      qual = I_PARTNER_CAPTURE && run;  // see (RULE_12)
    end

    // Interrupt pacing
    if (qual) begin
      next_st.cap_evt = 1'b1;
      if (mode == CM_ANY_EDGE || st.int_cnt >= st.con1[`ICU_CI_LSB +: 2]) begin
        next_st.irq = 1'b1;  // see (RULE_03) (RULE_04)
        next_st.int_cnt = 2'h0;
      end else begin
        next_st.int_cnt = st.int_cnt + 2'h1;
      end
    end

    // Write channels: each taken on its own, in either order
    if (st.rsp.awready && I_AXI.awvalid) begin
      next_st.rsp.awready = 1'b0;
      next_st.aw_got = 1'b1;
      next_st.awaddr = I_AXI.awaddr;
    end
    if (st.rsp.wready && I_AXI.wvalid) begin
      next_st.rsp.wready = 1'b0;
      next_st.w_got = 1'b1;
      next_st.wdata = I_AXI.wdata;
      next_st.wstrb = I_AXI.wstrb;
    end
    if (wr_now) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = `ICU_RESP_OKAY;
      case (st.awaddr)
        // Stored images keep only writable bits, so gaps read zero
        `ICU_CON1_ADDR: next_st.con1 = wr16(st.con1, st.wdata, st.wstrb,
                                           `ICU_CON1_WMASK); // see (RULE_22)
        `ICU_CON2_ADDR: next_st.con2 = wr16(st.con2, st.wdata, st.wstrb,
                                           `ICU_CON2_WMASK); // see (RULE_15) (RULE_22)
        `ICU_TMR_ADDR: next_st.timer = wr16(st.timer, st.wdata, st.wstrb, `ICU_TMR_WMASK);
        `ICU_BUF_ADDR: next_st.rsp.bresp = `ICU_RESP_OKAY;  // Buffer write ignored
        default: next_st.rsp.bresp = `ICU_RESP_SLVERR;  // Unmapped
      endcase
    end
    if (st.rsp.bvalid && I_AXI.bready) begin
      next_st.rsp.bvalid = 1'b0;
      next_st.rsp.awready = 1'b1;
      next_st.rsp.wready = 1'b1;
    end

    // Read channel: data one cycle after the address
    if (st.rsp.arready && I_AXI.arvalid) begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp = `ICU_RESP_OKAY;
      next_st.rsp.rdata = 32'h0000_0000;
      case (I_AXI.araddr)
        `ICU_CON1_ADDR: next_st.rsp.rdata[15:0] = con1_view;
        `ICU_CON2_ADDR: next_st.rsp.rdata[15:0] = st.con2;
        `ICU_TMR_ADDR: next_st.rsp.rdata[15:0] = st.timer;
        `ICU_BUF_ADDR: begin
          // An empty buffer reads zero and removes nothing
          if (st.count != 3'h0) begin
            next_st.rsp.rdata[15:0] = head;  // see (RULE_26)
            pop = 1'b1;
          end
        end
        default: next_st.rsp.rresp = `ICU_RESP_SLVERR;
      endcase
    end
    if (st.rsp.rvalid && I_AXI.rready) begin
      next_st.rsp.rvalid = 1'b0;
      next_st.rsp.arready = 1'b1;
    end

    // Capture buffer
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 2'h1;  // see (RULE_26)
    end
    if (qual) begin
      if (st.count == `ICU_FIFO_DEPTH && !pop) begin
        next_st.ovf = 1'b1;  // Stored values kept, see (RULE_25)
      end else begin
        next_st.fifo[st.wr_ptr] = st.timer;  // see (RULE_23) (RULE_25)
        next_st.wr_ptr = st.wr_ptr + 2'h1;
      end
    end
    next_st.count = st.count + {2'h0, qual && !(st.count == `ICU_FIFO_DEPTH && !pop)}
                  - {2'h0, pop};
    // Turning the channel off flushes the buffer and its flags
    if (mode == CM_OFF) begin
      next_st.count = 3'h0;
      next_st.wr_ptr = 2'h0;
      next_st.rd_ptr = 2'h0;
      next_st.ovf = 1'b0;
      next_st.int_cnt = 2'h0;
    end

    // Hardware set of the trigger status wins over a software clear
    if (fire) begin
      next_st.con2[`ICU_TSTAT_BIT] = 1'b1;  // see (RULE_15)
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Source select comes out of reset on the timer3 code
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= ST_RST;  // see (RULE_20)
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign O_AXI = st.rsp;
  assign O_IRQ = st.irq;
  assign O_CAPTURE_EVT = st.cap_evt;
  assign O_CASCADE_EN = st.con2[`ICU_CASC_BIT];
  assign O_TIMER_CARRY = st.carry;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_idle_freeze: assert property (halted && !wr_now |=> $stable(st.timer)) // see (RULE_01)
    else $error("timer moved while halted");
  a_rise_irq: assert property (mode == CM_RISE && st.con1[`ICU_CI_LSB +: 2] == 2'h0 && rise
      && live && !casc_upper |=> O_IRQ && O_CAPTURE_EVT) // see (RULE_03)
    else $error("rising edge gave no interrupt");
  a_fourth_irq: assert property (mode == CM_RISE && st.con1[`ICU_CI_LSB +: 2] == 2'h3
      && qual && st.int_cnt != 2'h3 |=> !O_IRQ) // see (RULE_03)
    else $error("interrupt before fourth capture");
  a_full_overflow: assert property (qual && st.count == `ICU_FIFO_DEPTH && !pop
      |=> st.ovf && st.count == `ICU_FIFO_DEPTH) // see (RULE_25)
    else $error("overflow not flagged");
  a_push_grows: assert property (qual && !pop && st.count < `ICU_FIFO_DEPTH
      |=> st.count == $past(st.count) + 3'h1) // see (RULE_25)
    else $error("capture not stored");
  a_pop_oldest: assert property (pop |=> st.rsp.rvalid && st.rsp.rdata[15:0] == $past(head)
      && st.count == $past(st.count) - 3'h1 + {2'h0, $past(qual)}) // see (RULE_26)
    else $error("buffer read wrong");
  a_fall_ignored: assert property (mode == CM_RISE && fall && !pop && !casc_upper
      |=> st.count == $past(st.count) && !O_CAPTURE_EVT) // see (RULE_07)
    else $error("falling edge captured");
  a_prescale_four: assert property (mode == CM_PRE4 && rise && live && !casc_upper
      && st.pre_cnt != `ICU_PRE4_LAST |=> !O_CAPTURE_EVT) // see (RULE_08)
    else $error("capture before fourth rise");
  a_wake_pin: assert property (mode == CM_SLEEP_PIN && I_CPU_SLEEP && rise
      |=> O_IRQ && !O_CAPTURE_EVT) // see (RULE_10)
    else $error("wake interrupt missing");
  a_held_clear: assert property (st.con2[`ICU_TRIGOP_BIT] && !st.con2[`ICU_TSTAT_BIT]
      && live && !wr_now |=> st.timer == 16'h0000) // see (RULE_14)
    else $error("untriggered timer not clear");
  a_trig_set: assert property (fire |=> st.con2[`ICU_TSTAT_BIT]) // see (RULE_15)
    else $error("trigger status not set");
  a_off_flush: assert property (mode == CM_OFF |=> st.count == 3'h0 && !st.ovf) // see (RULE_11)
    else $error("disabled channel kept data");

  c_overflow: cover property (!st.ovf ##1 st.ovf);
  c_fourth_irq: cover property (O_IRQ && st.con1[`ICU_CI_LSB +: 2] == 2'h3);
  c_buffer_read: cover property (pop ##1 st.count == 3'h0);
  c_triggered: cover property (st.con2[`ICU_TRIGOP_BIT] && fire ##1 st.con2[`ICU_TSTAT_BIT]);
endmodule

// >>> verification/cap_pin_src.sv
// Behavioural source of the external digital input seen by the capture channel
`timescale 1ns/1ps
module cap_pin_src (
  input wire logic i_mclk,  // Channel clock; the pin moves just after its rising edge
  output logic o_pin        // Digital level offered to the capture input
);
  // ****************************************************************
  // Pulse train generator
  // ****************************************************************
  // Idle low, so the first pulse always gives a clean rising edge
  initial o_pin = 1'b0;
  // High for hi cycles, then low for lo cycles, n times; whole cycles only,
  // because the channel samples the pin once per clock and would miss a glitch
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      o_pin <= 1'b1;
      repeat (hi) @(posedge i_mclk);
      o_pin <= 1'b0;
      repeat (lo) @(posedge i_mclk);
    end
  endtask
endmodule

// >>> verification/test_input_capture_unit.sv
// Self-checking bench for the input capture channel
`timescale 1ns/1ps
`include "icu_regs.svh"
`define CHECK_EQ(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_input_capture_unit;
  import icu_pkg::*;
  // ****************************************************************
  // Signals and design under test
  // ****************************************************************
  logic mclk = 1'b0;          // 20 MHz clock
  logic rst_n = 1'b0;         // Active-low reset
  axi_req_t ax = '0;          // Bus master requests
  axi_rsp_t rs;               // Bus answers
  logic cpu_idle = 1'b0;      // CPU idle level
  logic cpu_sleep = 1'b0;     // CPU sleep level
  logic [4:0] tclk = 5'h00;   // Timer clock ticks
  logic [31:0] src = 32'h0;   // Event sources, indexed by select code
  logic cap_pin;
  logic irq;
  logic cap_evt;
  logic casc_en;
  logic carry;                // Timer wrap pulse
  logic [31:0] rdat;          // Last read data
  logic [1:0] rresp_q;        // Last read response
  int num_errors = 0;
  int n_tests = 0;
  int n_cap = 0;              // Capture pulses seen
  int n_irq = 0;              // Interrupt pulses seen
  int n_carry = 0;            // Carry pulses seen
  input_capture_unit #(.CHANNEL(1), .IS_UPPER(1'b0)) i_input_capture_unit (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_AXI(ax), .I_CAP_PIN(cap_pin),
    .I_CPU_IDLE(cpu_idle), .I_CPU_SLEEP(cpu_sleep), .I_TIMER_CLOCK(tclk),
    .I_OC_EVENT(src[8:1]), .I_TRIG_GEN_OUT({src[31:29], src[10]}),
    .I_TIMER_EVENT(src[15:11]), .I_IC_EVENT(src[23:16]), .I_CMP_EVENT(src[26:24]),
    .I_ADC_EVENT(src[27]), .I_CHARGE_TIME_EVENT(src[28]), .I_PARTNER_CASCADE(1'b0),
    .I_PARTNER_CARRY(1'b0), .I_PARTNER_CAPTURE(1'b0), .O_IRQ(irq),
    .O_CAPTURE_EVT(cap_evt), .O_CASCADE_EN(casc_en), .O_TIMER_CARRY(carry), .O_AXI(rs));
  cap_pin_src i_cap_pin_src (.i_mclk(mclk), .o_pin(cap_pin));
  // Clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Pulse counters; pulses last one cycle so each edge sees one at most
  always @(posedge mclk) begin
    if (cap_evt === 1'b1) n_cap++;
    if (irq === 1'b1) n_irq++;
    if (carry === 1'b1) n_carry++;
  end
  // ****************************************************************
  // Bus and helper tasks
  // ****************************************************************
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    ax.awvalid <= 1'b1;
    ax.awaddr <= a;
    ax.wvalid <= 1'b1;
    ax.wdata <= {16'h0000, d};
    ax.wstrb <= 4'hF;
    ax.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rs.awready) ax.awvalid <= 1'b0;
      if (rs.wready) ax.wvalid <= 1'b0;
    end while (!rs.bvalid);
  endtask
  // Read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [11:0] a);
    ax.arvalid <= 1'b1;
    ax.araddr <= a;
    ax.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rs.arready) ax.arvalid <= 1'b0;
    end while (!rs.rvalid);
    rdat = rs.rdata;
    rresp_q = rs.rresp;
  endtask
  // Lets pipelined pulses land before counting
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask
  // Clears capture state, then sets the wanted control word
  task automatic set_con1(input logic [15:0] d);
    wr(`ICU_CON1_ADDR, 16'h1C00);
    wr(`ICU_CON1_ADDR, d);
    n_cap = 0;
    n_irq = 0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(`ICU_CON1_ADDR);
    `CHECK_EQ(rdat, 32'h0000_0000)
    rd(`ICU_CON2_ADDR);
    `CHECK_EQ(rdat, 32'h0000_000D)
    wr(`ICU_CON1_ADDR, 16'hFFFF);
    rd(`ICU_CON1_ADDR);
    `CHECK_EQ(rdat, 32'h0000_3C67)
    wr(`ICU_CON2_ADDR, 16'hFFFF);
    rd(`ICU_CON2_ADDR);
    `CHECK_EQ(rdat, 32'h0000_01DF)
    settle();
    `CHECK_EQ(casc_en, 1'b1)
    wr(`ICU_CON2_ADDR, 16'h0000);
    settle();
    `CHECK_EQ(casc_en, 1'b0)
    rd(12'h010);
    `CHECK_EQ(rresp_q, `ICU_RESP_SLVERR)
  endtask
  // Each time base counts its own tick alone driven; a reserved code stops the timer with every tick driven
  task automatic t_tbase();
    logic [4:0] tick [6] = '{5'h04, 5'h02, 5'h08, 5'h10, 5'h01, 5'h1F};
    logic [15:0] t0;
    for (int i = 0; i < 6; i++) begin
      wr(`ICU_CON1_ADDR, 16'(i << 10));
      rd(`ICU_TMR_ADDR);
      t0 = rdat[15:0];
      tclk <= tick[i];
      repeat (5) @(posedge mclk);
      tclk <= 5'h00;
      rd(`ICU_TMR_ADDR);
      `CHECK_EQ(rdat[15:0] - t0, (i == 5) ? 16'h0000 : 16'h0005)
    end
    // Preset near the top while stopped, then let the peripheral clock wrap it once
    wr(`ICU_TMR_ADDR, 16'hFFFE);
    n_carry = 0;
    wr(`ICU_CON1_ADDR, 16'h1C00);
    settle();
    `CHECK_EQ(n_carry, 1)
  endtask
  // Rises at 0, 13, 19, 25, 31: the fifth overflows and must not overwrite
  task automatic t_fifo();
    logic [15:0] v [4];
    set_con1(16'h1C03);
    i_cap_pin_src.pulses(1, 3, 10);
    i_cap_pin_src.pulses(4, 3, 3);
    settle();
    rd(`ICU_CON1_ADDR);
    `CHECK_EQ(rdat[4:3], 2'h3)
    for (int i = 0; i < 4; i++) begin
      rd(`ICU_BUF_ADDR);
      v[i] = rdat[15:0];
    end
    `CHECK_EQ(v[1] - v[0], 16'h000D)
    `CHECK_EQ(v[3] - v[1], 16'h000C)
    rd(`ICU_CON1_ADDR);
    `CHECK_EQ(rdat[4:3], 2'h2)
    rd(`ICU_BUF_ADDR);
    `CHECK_EQ(rdat, 32'h0000_0000)
    set_con1(16'h1C00);
    rd(`ICU_CON1_ADDR);
    `CHECK_EQ(rdat[4], 1'b0)
  endtask
  // Every mode against 16 pulses with the count field at every fourth
  task automatic t_modes();
    int ecap [8] = '{0, 32, 16, 16, 4, 1, 0, 0};
    int eirq [8] = '{0, 32, 4, 4, 1, 0, 0, 0};
    for (int m = 0; m < 8; m++) begin
      set_con1(16'h1C60 | 16'(m));
      i_cap_pin_src.pulses(16, 2, 2);
      settle();
      `CHECK_EQ(n_cap, ecap[m])
      `CHECK_EQ(n_irq, eirq[m])
      rd(`ICU_CON1_ADDR);
      `CHECK_EQ(rdat[4], (ecap[m] > 4))
    end
    cpu_sleep <= 1'b1;
    n_irq = 0;
    i_cap_pin_src.pulses(2, 2, 2);
    settle();
    `CHECK_EQ(n_irq, 2)
    cpu_sleep <= 1'b0;
  endtask
  task automatic t_ci();
    int eirq [4] = '{4, 2, 1, 1};
    for (int c = 0; c < 4; c++) begin
      set_con1(16'h1C03 | 16'(c << 5));
      i_cap_pin_src.pulses(4, 2, 2);
      settle();
      `CHECK_EQ(n_irq, eirq[c])
    end
  endtask
  task automatic t_idle();
    cpu_idle <= 1'b1;
    set_con1(16'h3C03);
    i_cap_pin_src.pulses(3, 2, 2);
    settle();
    `CHECK_EQ(n_cap, 0)
    set_con1(16'h1C03);
    i_cap_pin_src.pulses(3, 2, 2);
    settle();
    `CHECK_EQ(n_cap, 3)
    cpu_idle <= 1'b0;
  endtask
  // Trigger mode: every select code fired once; the own channel is skipped
  task automatic t_trig();
    logic exp;
    set_con1(16'h1C00);
    for (int c = 0; c < 32; c++) begin
      if (c == 16) continue;
      exp = !(c inside {0, 9, 29, 30, 31});
      wr(`ICU_CON2_ADDR, 16'h0080 | 16'(c));
      rd(`ICU_TMR_ADDR);
      `CHECK_EQ(rdat, 32'h0000_0000)
      src[c] <= 1'b1;
      @(posedge mclk);
      src <= 32'h0;
      repeat (3) @(posedge mclk);
      rd(`ICU_CON2_ADDR);
      `CHECK_EQ(rdat[6], exp)
      rd(`ICU_TMR_ADDR);
      `CHECK_EQ(rdat != 32'h0, exp)
    end
    wr(`ICU_CON2_ADDR, 16'h000B);
    repeat (40) @(posedge mclk);
    src[11] <= 1'b1;
    @(posedge mclk);
    src <= 32'h0;
    rd(`ICU_TMR_ADDR);
    `CHECK_EQ(rdat[15:0] < 16'h0008, 1'b1)
  endtask
  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_tbase();
    t_fifo();
    t_modes();
    t_ci();
    t_idle();
    t_trig();
    summarize();
  end
  // Whole run needs under two thousand cycles; this cuts a hang short
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    summarize();
  end
endmodule
